// [hw/cop_defines.svh]
// Constants for the CANopen process-data and service-data node.
`ifndef COP_DEFINES_SVH
`define COP_DEFINES_SVH
`define COP_SDO_RX_BASE 11'h600
`define COP_SDO_TX_BASE 11'h580
`define COP_CMD_WR4 8'h23
`define COP_CMD_WR2 8'h2b
`define COP_CMD_WR1 8'h2f
`define COP_CMD_RD 8'h40
`define COP_CMD_ABORT 8'h80
`define COP_RSP_RD4 8'h43
`define COP_RSP_RD2 8'h4b
`define COP_RSP_RD1 8'h4f
`define COP_RSP_WR 8'h60
`define COP_RSP_ABORT 8'h80
`define COP_TT_ACYC 8'h00
`define COP_TT_SYNC_MAX 8'hf0
`define COP_TT_MFR 8'hfe
`define COP_TT_EVENT 8'hff
`define COP_SYNC_ID 11'h080
`define COP_MAP_N 4
`define COP_OD_N 8
`define COP_PDO_MAX_BYTES 4'h8
`define COP_INHIBIT_DIV 8'h64
`define COP_TIMER_DIV 18'h3d090
`define COP_NMT_PREOP 2'h1
`define COP_NMT_OP 2'h2
`endif

// [hw/cop_pkg.sv]
// Types for the CANopen process-data and service-data node.
package cop_pkg;
	typedef enum logic [1:0] {
		COP_IDLE = 2'h0,
		COP_EXEC = 2'h1,
		COP_RESP = 2'h3
	} cop_sdo_state_t;
	typedef logic [7:0] cop_byte_t;
	typedef logic [10:0] cop_id_t;
endpackage

// [hw/cop_od_store.sv]
// Object dictionary store: index/subindex lookup, byte-lane write.
`timescale 1ns/1ns
`include "cop_defines.svh"
module cop_od_store (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [15:0] rdIndex,
	input wire logic [7:0] rdSub,
	output logic rdHit,
	output logic [31:0] rdData,
	output logic [5:0] rdBits,
	input wire logic [15:0] mapIndex [`COP_MAP_N],
	input wire logic [7:0] mapSub [`COP_MAP_N],
	output logic [31:0] mapData [`COP_MAP_N],
	input wire logic wrEn,
	input wire logic [3:0] wrBe,
	input wire logic [31:0] wrData,
	input wire logic [15:0] objIndex [`COP_OD_N],
	input wire logic [7:0] objSub [`COP_OD_N],
	input wire logic [5:0] objBits [`COP_OD_N],
	output logic [31:0] objValue [`COP_OD_N]
);
	import cop_pkg::*;
	logic [31:0] mem [`COP_OD_N];
	always_comb begin
		rdHit = 1'b0;
		rdData = 32'h0;
		rdBits = 6'h0;
		for (int i = 0; i < `COP_OD_N; i++) begin
			if (objIndex[i] == rdIndex && objSub[i] == rdSub) begin
				rdHit = 1'b1;
				rdData = mem[i];
				rdBits = objBits[i];
			end
		end
		for (int m = 0; m < `COP_MAP_N; m++) begin
			mapData[m] = 32'h0;
			for (int i = 0; i < `COP_OD_N; i++) begin
				if (objIndex[i] == mapIndex[m] && objSub[i] == mapSub[m]) begin
					mapData[m] = mem[i];
				end
			end
		end
	end
	// Every stored object is writable as well as readable.
	genvar g;
	generate
		for (g = 0; g < `COP_OD_N; g++) begin : gObj
			always_ff @(posedge mclk or negedge arst_n) begin
				if (!arst_n) begin
					mem[g] <= 32'h0;
				end else if (wrEn && objIndex[g] == rdIndex
						&& objSub[g] == rdSub) begin
					for (int b = 0; b < 4; b++) begin
						if (wrBe[b]) begin
							mem[g][b*8 +: 8] <= wrData[b*8 +: 8];
						end
					end
				end
			end
			assign objValue[g] = mem[g];
		end
	endgenerate
endmodule

// [hw/cop_node.sv]
// CANopen node: transmit process-data scheduler and expedited SDO server.
// Functional notes
// - Process-data payload is one to eight bytes, all application data.
// - Received process data never produces a reply frame.
// - Node filters received frames by identifier itself.
// - Payload packed from mapping list entries in order, lengths in bits.
// - Channel holds identifier, transmission type, inhibit time, event timer.
// - Type 0 sends on SYNC only after mapped data changed.
// - Type 1 to 240 sends once every N SYNC messages.
// - Type 255 sends on data change or event, ignoring SYNC.
// - Type 254 behaves exactly like type 255.
// - Every read or write request taken by an idle server gets exactly one response.
// - Client or server may abort an SDO transfer.
// - Responses go on 580h plus node with echoed index and subindex.
// - Codes 23h, 2Bh, 2Fh write four, two, one bytes.
// - Code 40h reads, code 80h aborts the current transfer.
// - Read answers use 43h, 4Bh or 4Fh by data length.
// - Writes confirm with 60h; aborted transfers answer 80h.
// - Objects over four bytes need segments ending with a flag; the node serves only expedited transfers and aborts other commands with 80h.
// - All dictionary objects are readable and writable over SDO.
// - Objects addressed by 16-bit index and 8-bit subindex.
// - SDO in pre-operational and operational, process data operational.
`timescale 1ns/1ns
`include "cop_defines.svh"
module cop_node (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [6:0] nodeId,
	input wire logic [1:0] nmtState,
	input wire logic rxValid,
	input wire cop_pkg::cop_id_t rxId,
	input wire logic [3:0] rxLen,
	input wire logic [63:0] rxData,
	input wire logic txReady,
	output logic txValid,
	output cop_pkg::cop_id_t txId,
	output logic [3:0] txLen,
	output logic [63:0] txData,
	input wire cop_pkg::cop_id_t pdoCobId,
	input wire logic [7:0] pdoTransType,
	input wire logic [15:0] pdoInhibit,
	input wire logic [15:0] pdoEventMs,
	input wire logic pdoEventTrig,
	input wire logic [2:0] mapCount,
	input wire logic [15:0] mapIndex [`COP_MAP_N],
	input wire logic [7:0] mapSub [`COP_MAP_N],
	input wire logic [5:0] mapBits [`COP_MAP_N],
	input wire logic [15:0] objIndex [`COP_OD_N],
	input wire logic [7:0] objSub [`COP_OD_N],
	input wire logic [5:0] objBits [`COP_OD_N],
	output logic [31:0] objValue [`COP_OD_N],
	output logic sdoBusy,
	output logic pdoSentPulse
);
	import cop_pkg::*;
	typedef struct packed {
		cop_sdo_state_t sdo;
		logic [7:0] cmd;
		logic [15:0] idx;
		logic [7:0] sub;
		logic [31:0] dat;
		logic [7:0] syncCnt;
		logic pdoPend;
		logic changed;
		logic [63:0] lastPay;
		logic [6:0] inhDiv;
		logic [15:0] inhCnt;
		logic [17:0] msDiv;
		logic [15:0] evCnt;
		logic txValid;
		cop_id_t txId;
		logic [3:0] txLen;
		logic [63:0] txData;
		logic sent;
	} cop_state_t;
	cop_state_t st_reg, st_next;
	logic rdHit;
	logic [31:0] rdData;
	logic [5:0] rdBits;
	logic [31:0] mapData [`COP_MAP_N];
	logic wrEn;
	logic [3:0] wrBe;
	logic [63:0] payload;
	// Wide enough for four full entries, so an overlong map cannot wrap.
	logic [8:0] payBits;
	logic [63:0] rxBytes;
	logic pendSet;
	logic isSdoReq, isSync, sdoOk, pdoOk, asyncType, syncType;

	cop_od_store uStore (
		.mclk(mclk),
		.arst_n(arst_n),
		.rdIndex(st_reg.idx),
		.rdSub(st_reg.sub),
		.rdHit(rdHit),
		.rdData(rdData),
		.rdBits(rdBits),
		.mapIndex(mapIndex),
		.mapSub(mapSub),
		.mapData(mapData),
		.wrEn(wrEn),
		.wrBe(wrBe),
		.wrData(st_reg.dat),
		.objIndex(objIndex),
		.objSub(objSub),
		.objBits(objBits),
		.objValue(objValue)
	);

	// Bytes beyond the received length never crossed the bus; read as zero.
	genvar gb;
	generate
		for (gb = 0; gb < `COP_PDO_MAX_BYTES; gb++) begin : gLane
			assign rxBytes[gb*8 +: 8] = 4'(gb) < rxLen
				? rxData[gb*8 +: 8] : 8'h00;
		end
	endgenerate

	// Mapped objects packed LSB first in list order.
	always_comb begin
		payload = 64'h0;
		payBits = 9'h0;
		for (int m = 0; m < `COP_MAP_N; m++) begin
			if (3'(m) < mapCount) begin
				// Bits past the 64th are dropped; the frame length is capped too.
				for (int b = 0; b < 32; b++) begin
					if (6'(b) < mapBits[m] && 9'(32'(payBits) + b) < 9'h40) begin
						payload[6'(32'(payBits) + b)] = mapData[m][b];
					end
				end
				payBits = 9'(payBits + 9'(mapBits[m]));
			end
		end
	end

	always_comb begin
		sdoOk = nmtState == `COP_NMT_PREOP || nmtState == `COP_NMT_OP;
		pdoOk = nmtState == `COP_NMT_OP;
		// Only the node's own SDO and SYNC identifiers are taken.
		isSdoReq = rxValid && rxId == 11'(`COP_SDO_RX_BASE + 11'(nodeId));
		isSync = rxValid && rxId == `COP_SYNC_ID && pdoOk;
		asyncType = pdoTransType == `COP_TT_EVENT
			|| pdoTransType == `COP_TT_MFR;
		// Types 241 to 253 are reserved and never schedule a frame.
		syncType = pdoTransType != `COP_TT_ACYC
			&& pdoTransType <= `COP_TT_SYNC_MAX;
		wrEn = 1'b0;
		wrBe = 4'h0;
		pendSet = 1'b0;
		st_next = st_reg;
		st_next.sent = 1'b0;
		if (st_reg.txValid && txReady) begin
			st_next.txValid = 1'b0;
		end
		// Inhibit counts in ticks of a fixed cycle length; a frame waits for zero.
		if (st_reg.inhDiv != 7'h0) begin
			st_next.inhDiv = st_reg.inhDiv - 7'h1;
		end else if (st_reg.inhCnt != 16'h0) begin
			st_next.inhDiv = 7'(`COP_INHIBIT_DIV - 8'h1);
			st_next.inhCnt = st_reg.inhCnt - 16'h1;
		end
		// The event timer free-runs a one-millisecond tick off the device clock.
		if (st_reg.msDiv != 18'h0) begin
			st_next.msDiv = st_reg.msDiv - 18'h1;
		end else begin
			st_next.msDiv = `COP_TIMER_DIV - 18'h1;
			if (st_reg.evCnt != 16'h0) begin
				st_next.evCnt = st_reg.evCnt - 16'h1;
			end
		end
		// Scheduling per transmission type.
		if (isSync && pdoTransType == `COP_TT_ACYC && st_reg.changed) begin
			st_next.pdoPend = 1'b1;
			pendSet = 1'b1;
			st_next.changed = 1'b0;
		end
		if (isSync && syncType) begin
			if (st_reg.syncCnt + 8'h1 >= pdoTransType) begin
				st_next.syncCnt = 8'h0;
				st_next.pdoPend = 1'b1;
				pendSet = 1'b1;
			end else begin
				st_next.syncCnt = st_reg.syncCnt + 8'h1;
			end
		end
		if (asyncType && pdoOk && (st_reg.changed || pdoEventTrig
				|| (pdoEventMs != 16'h0 && st_reg.evCnt == 16'h0
				&& st_reg.msDiv == 18'h0))) begin
			st_next.pdoPend = 1'b1;
			pendSet = 1'b1;
			st_next.changed = 1'b0;
			st_next.evCnt = pdoEventMs;
		end
		// A change in the cycle that consumes the old one still counts.
		if (payload != st_reg.lastPay) begin
			st_next.changed = 1'b1;
			st_next.lastPay = payload;
		end
		// SDO answers take priority on the shared transmit port.
		case (st_reg.sdo)
			COP_IDLE: begin
				// Received process data is consumed silently.
				// A request that meets a busy server is dropped, not queued.
				if (isSdoReq && sdoOk) begin
					st_next.cmd = rxBytes[7:0];
					st_next.idx = rxBytes[23:8];
					st_next.sub = rxBytes[31:24];
					st_next.dat = rxBytes[63:32];
					st_next.sdo = COP_EXEC;
				end
			end
			COP_EXEC: begin
				st_next.txData = 64'h0;
				st_next.txData[31:8] = {st_reg.sub, st_reg.idx};
				st_next.txId = 11'(`COP_SDO_TX_BASE + 11'(nodeId));
				st_next.txLen = `COP_PDO_MAX_BYTES;
				st_next.sdo = COP_RESP;
				case (st_reg.cmd)
					`COP_CMD_WR4, `COP_CMD_WR2, `COP_CMD_WR1: begin
						if (rdHit) begin
							wrEn = 1'b1;
							wrBe = st_reg.cmd == `COP_CMD_WR4 ? 4'hf
								: st_reg.cmd == `COP_CMD_WR2 ? 4'h3 : 4'h1;
							st_next.txData[7:0] = `COP_RSP_WR;
						end else begin
							st_next.txData[7:0] = `COP_RSP_ABORT;
						end
					end
					`COP_CMD_RD: begin
						if (rdHit) begin
							st_next.txData[63:32] = rdData;
							st_next.txData[7:0] = rdBits > 6'h10 ? `COP_RSP_RD4
								: rdBits > 6'h8 ? `COP_RSP_RD2
								: `COP_RSP_RD1;
						end else begin
							st_next.txData[7:0] = `COP_RSP_ABORT;
						end
					end
					// Client abort ends the transfer; echoed as abort.
					`COP_CMD_ABORT: st_next.txData[7:0] = `COP_RSP_ABORT;
					// Segmented transfers are unsupported, so abort.
					default: st_next.txData[7:0] = `COP_RSP_ABORT;
				endcase
				st_next.txValid = 1'b1;
			end
			COP_RESP: begin
				if (st_reg.txValid && txReady) begin
					st_next.sdo = COP_IDLE;
				end
			end
			default: st_next.sdo = COP_IDLE;
		endcase
		// A frame still standing on the port must not be overwritten, so the
		// answer and its write wait in EXEC until that frame is taken.
		if (st_reg.sdo == COP_EXEC && st_reg.txValid) begin
			wrEn = 1'b0;
			st_next.sdo = COP_EXEC;
			st_next.txValid = !txReady;
			st_next.txId = st_reg.txId;
			st_next.txLen = st_reg.txLen;
			st_next.txData = st_reg.txData;
		end
		if (st_reg.sdo == COP_IDLE && !st_reg.txValid && st_reg.pdoPend
				&& !isSdoReq && pdoOk && st_reg.inhCnt == 16'h0
				&& st_reg.inhDiv == 7'h0) begin
			// A request raised in this very cycle stays pending.
			st_next.pdoPend = pendSet;
			st_next.txValid = 1'b1;
			st_next.txId = pdoCobId;
			st_next.txData = payload;
			st_next.txLen = payBits == 9'h0 ? 4'h1
				: payBits >= 9'h40 ? `COP_PDO_MAX_BYTES
				: 4'((payBits + 9'h7) >> 3);
			st_next.inhCnt = pdoInhibit;
			st_next.sent = 1'b1;
		end
		// Leaving operational drops queued frames and restarts the SYNC count.
		if (!pdoOk) begin
			st_next.pdoPend = 1'b0;
			st_next.syncCnt = 8'h0;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	always_comb begin
		txValid = st_reg.txValid;
		txId = st_reg.txId;
		txLen = st_reg.txLen;
		txData = st_reg.txData;
		sdoBusy = st_reg.sdo != COP_IDLE;
		pdoSentPulse = st_reg.sent;
	end
endmodule

// [tb/cop_node_assertions.sv]
// Concurrent checks on the node's frame ports.
`timescale 1ns/1ns
module cop_node_chk (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [6:0] nodeId,
	input wire logic [1:0] nmtState,
	input wire logic rxValid,
	input wire cop_pkg::cop_id_t rxId,
	input wire logic [63:0] rxData,
	input wire logic txReady,
	input wire logic txValid,
	input wire cop_pkg::cop_id_t txId,
	input wire logic [3:0] txLen,
	input wire logic [63:0] txData,
	input wire logic sdoBusy,
	input wire logic pdoSentPulse,
	input wire cop_pkg::cop_id_t pdoCobId
);
	import cop_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	logic take;
	logic [7:0] cmd;
	// A request only counts as taken here when the frame is free, so timing is exact.
	assign cmd = rxData[7:0];
	assign take = rxValid && !sdoBusy && !txValid &&
		nmtState inside {2'h1, 2'h2} && rxId == 11'h600 + 11'(nodeId);
	a_take_busy: assert property (take |=> sdoBusy)
		else $error("request not taken");
	a_answer_id: assert property (take |-> ##2 txValid &&
		txId == 11'h580 + 11'(nodeId)) else $error("bad answer id");
	a_echo_index: assert property (take |-> ##2
		txData[31:8] == $past(rxData[31:8], 2)) else $error("bad echo");
	a_abort_code: assert property (take && cmd == 8'h80 |-> ##2
		txData[7:0] == 8'h80) else $error("bad abort code");
	a_tx_stands: assert property (txValid && !txReady |=>
		txValid && $stable(txId) && $stable(txData)) else $error("tx moved");
	a_one_answer: assert property (txValid && txReady && sdoBusy
		&& txId == 11'h580 + 11'(nodeId)
		|=> !txValid && !sdoBusy) else $error("extra answer");
	a_wrong_state: assert property (rxValid && !sdoBusy &&
		!(nmtState inside {2'h1, 2'h2}) |=> !sdoBusy) else $error("served");
	a_pdo_frame: assert property (pdoSentPulse |-> txValid &&
		txId == pdoCobId && txLen inside {[4'h1:4'h8]}) else $error("bad pdo");
	cover property (take && cmd == 8'h40);
	cover property (pdoSentPulse);
	cover property (txValid && !txReady);
endmodule
bind cop_node cop_node_chk chk (.mclk(mclk), .arst_n(arst_n),
	.nodeId(nodeId), .nmtState(nmtState), .rxValid(rxValid), .rxId(rxId),
	.rxData(rxData), .txReady(txReady), .txValid(txValid), .txId(txId),
	.txLen(txLen), .txData(txData), .sdoBusy(sdoBusy),
	.pdoSentPulse(pdoSentPulse), .pdoCobId(pdoCobId));

// [tb/cop_can_master.sv]
// Network master: SYNC producer, SDO client and stalling frame sink.
`timescale 1ns/1ns
module cop_can_master (
	input wire logic mclk,
	input wire logic [6:0] nodeId,
	output logic rxValid,
	output cop_pkg::cop_id_t rxId,
	output logic [3:0] rxLen,
	output logic [63:0] rxData,
	output logic txReady,
	input wire logic txValid,
	input wire cop_pkg::cop_id_t txId,
	input wire logic [3:0] txLen,
	input wire logic [63:0] txData
);
	import cop_pkg::*;
	logic [78:0] got [$];
	int stall = 0;
	int waitCnt = 0;
	initial begin
		rxValid = 1'b0;
		rxId = 11'h000;
		rxLen = 4'h0;
		rxData = 64'h0;
		txReady = 1'b0;
	end
	// Frames are only taken off the bus, never answered.
	always @(posedge mclk) begin
		if (txValid && txReady) begin
			got.push_back({txId, txLen, txData});
			txReady <= 1'b0;
			waitCnt <= 0;
		end else if (txValid) begin
			waitCnt <= waitCnt + 1;
			txReady <= waitCnt >= stall;
		end
	end
	// Data lines flip once the frame is over so stale bytes never match.
	task automatic send(input cop_id_t id, input logic [3:0] len,
		input logic [63:0] data);
		@(posedge mclk);
		rxValid <= 1'b1;
		rxId <= id;
		rxLen <= len;
		rxData <= data;
		@(posedge mclk);
		rxValid <= 1'b0;
		rxData <= ~data;
	endtask
	task automatic sdo(input logic [7:0] cmd, input logic [15:0] idx,
		input logic [7:0] sub, input logic [31:0] data);
		send(11'h600 + 11'(nodeId), 4'h8, {data, sub, idx, cmd});
	endtask
endmodule

// [tb/cop_node_test.sv]
// Bench for the node: master model, reference values and frame checks.
`timescale 1ns/1ns
`include "cop_defines.svh"
module cop_node_test;
	import cop_pkg::*;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic [6:0] nodeId = 7'h00;
	logic [1:0] nmtState = 2'h0;
	cop_id_t pdoCobId = 11'h181;
	logic [7:0] pdoTransType = 8'h00;
	logic pdoEventTrig = 1'b0;
	logic [15:0] pdoInhibit = 16'h0;
	// The event timer stays off: its shortest period outlasts the run.
	logic [15:0] pdoEventMs = 16'h0;
	logic [2:0] mapCount = 3'h2;
	logic [15:0] mapIndex [`COP_MAP_N] = '{16'h2002, 16'h2001, 16'h0, 16'h0};
	logic [7:0] mapSub [`COP_MAP_N] = '{default: 8'h01};
	logic [5:0] mapBits [`COP_MAP_N] = '{6'h08, 6'h10, 6'h00, 6'h00};
	logic [15:0] objIndex [`COP_OD_N];
	logic [7:0] objSub [`COP_OD_N] = '{default: 8'h01};
	logic [5:0] objBits [`COP_OD_N];
	logic [31:0] objValue [`COP_OD_N];
	logic rxValid, txReady, txValid, sdoBusy, pdoSentPulse;
	cop_id_t rxId, txId;
	logic [3:0] rxLen, txLen;
	logic [63:0] rxData, txData;
	logic [7:0] wrCode [3] = '{8'h23, 8'h2b, 8'h2f};
	logic [7:0] rdCode [3] = '{8'h43, 8'h4b, 8'h4f};
	logic [31:0] mask [3] = '{32'hffffffff, 32'hffff, 32'hff};
	logic [31:0] od [3] = '{default: 32'h0};
	logic [7:0] tt [4] = '{8'h01, 8'hf0, 8'hfe, 8'hff};
	logic [7:0] seed = 8'h1c;
	logic [78:0] fr;
	int failCount = 0;
	int comparisons = 0;
	always #2 mclk = ~mclk;
	cop_node dut (.mclk(mclk), .arst_n(arst_n), .nodeId(nodeId),
		.nmtState(nmtState), .rxValid(rxValid), .rxId(rxId), .rxLen(rxLen),
		.rxData(rxData), .txReady(txReady), .txValid(txValid), .txId(txId),
		.txLen(txLen), .txData(txData), .pdoCobId(pdoCobId),
		.pdoTransType(pdoTransType), .pdoInhibit(pdoInhibit),
		.pdoEventMs(pdoEventMs),
		.pdoEventTrig(pdoEventTrig), .mapCount(mapCount), .mapIndex(mapIndex),
		.mapSub(mapSub), .mapBits(mapBits), .objIndex(objIndex),
		.objSub(objSub), .objBits(objBits), .objValue(objValue),
		.sdoBusy(sdoBusy), .pdoSentPulse(pdoSentPulse));
	cop_can_master m (.mclk(mclk), .nodeId(nodeId), .rxValid(rxValid),
		.rxId(rxId), .rxLen(rxLen), .rxData(rxData), .txReady(txReady),
		.txValid(txValid), .txId(txId), .txLen(txLen), .txData(txData));
	function automatic logic [31:0] rnd();
		for (int i = 0; i < 4; i++) begin
			seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
			rnd = {rnd[23:0], seed};
		end
	endfunction
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failCount++;
			$display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic endSim();
		$display("comparisons=%0d failCount=%0d", comparisons, failCount);
		if (failCount == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic settle();
		repeat (12) @(posedge mclk);
	endtask
	task automatic pop();
		int n;
		n = 0;
		while (m.got.size() == 0 && n < 64) begin
			@(posedge mclk);
			n++;
		end
		fr = m.got.size() > 0 ? m.got.pop_front() : 79'h0;
	endtask
	task automatic sdoTx(input logic [7:0] cmd, input logic [15:0] idx,
		input logic [31:0] data, input logic [7:0] code);
		m.sdo(cmd, idx, 8'h01, data);
		pop();
		chk(fr[78:68], 11'h580 + 11'(nodeId));
		chk(fr[31:0], {8'h01, idx, code});
		chk(fr[67:64], 4'h8);
	endtask
	initial begin
		for (int i = 0; i < `COP_OD_N; i++) begin
			objIndex[i] = 16'h2000 + 16'(i);
			objBits[i] = i % 3 == 0 ? 6'h20 : i % 3 == 1 ? 6'h10 : 6'h08;
		end
	end
	initial begin
		#(40000 * 4);
		failCount++;
		endSim();
	end
	initial begin
		logic [31:0] d;
		repeat (20) @(posedge mclk);
		arst_n <= 1'b1;
		nodeId <= 7'(rnd()) | 7'h01;
		nmtState <= 2'h1;
		m.stall = 2;
		repeat (2) @(posedge mclk);
		for (int i = 0; i < 3; i++) begin
			d = rnd() & mask[i];
			sdoTx(wrCode[i], 16'h2000 + 16'(i), d, 8'h60);
			od[i] = d;
			sdoTx(8'h40, 16'h2000 + 16'(i), 32'h0, rdCode[i]);
			chk(fr[63:32], d);
			chk(objValue[i], d);
		end
		sdoTx(8'h55, 16'h2000, 32'h0, 8'h80);
		sdoTx(8'h40, 16'h3000, 32'h0, 8'h80);
		sdoTx(8'h80, 16'h2001, 32'h0, 8'h80);
		nmtState <= 2'h0;
		m.sdo(8'h40, 16'h2000, 8'h01, 32'h0);
		settle();
		chk(m.got.size(), 0);
		nmtState <= 2'h2;
		m.send(11'h600 + 11'(nodeId ^ 7'h40), 4'h8, 64'h40);
		m.send(11'h201, 4'h8, {rnd(), rnd()});
		settle();
		chk(m.got.size(), 0);
		m.send(11'h080, 4'h0, 64'h0);
		settle();
		m.got.delete();
		m.send(11'h080, 4'h0, 64'h0);
		settle();
		chk(m.got.size(), 0);
		d = {24'h0, ~od[2][7:0]};
		sdoTx(8'h2f, 16'h2002, d, 8'h60);
		od[2] = d;
		m.send(11'h080, 4'h0, 64'h0);
		pop();
		chk(fr[23:0], {od[1][15:0], od[2][7:0]});
		for (int k = 0; k < 2; k++) begin
			pdoTransType <= tt[k];
			for (int s = 0; s < 2 * tt[k]; s++) begin
				m.send(11'h080, 4'h0, 64'h0);
				settle();
			end
			chk(m.got.size(), 2);
			pop();
			chk(fr[78:64], {pdoCobId, 4'h3});
			chk(fr[23:0], {od[1][15:0], od[2][7:0]});
			m.got.delete();
		end
		for (int k = 2; k < 4; k++) begin
			pdoTransType <= tt[k];
			m.send(11'h080, 4'h0, 64'h0);
			settle();
			chk(m.got.size(), 0);
			@(posedge mclk) pdoEventTrig <= 1'b1;
			@(posedge mclk) pdoEventTrig <= 1'b0;
			pop();
			chk(fr[78:68], pdoCobId);
		end
		// Two inhibit ticks hold back a second event frame for about 200 cycles.
		pdoInhibit <= 16'h0002;
		@(posedge mclk) pdoEventTrig <= 1'b1;
		@(posedge mclk) pdoEventTrig <= 1'b0;
		pop();
		chk(fr[78:68], pdoCobId);
		@(posedge mclk) pdoEventTrig <= 1'b1;
		@(posedge mclk) pdoEventTrig <= 1'b0;
		repeat (150) @(posedge mclk);
		chk(m.got.size(), 0);
		repeat (100) @(posedge mclk);
		chk(m.got.size(), 1);
		endSim();
	end
endmodule
